// file: bmcr_regs.sv
// Battery monitor control and status register bank
//
// Summary of operation
// [RQ1] Fault flags set on event, stay until cleared
// [RQ2] Protection register bit layout, flags to enables
// [RQ3] Block 1 recall loads enables from 30h
// [RQ4] Pin mirror bits read back control outputs
// [RQ5] Charge enable zero forces charge output high
// [RQ6] Discharge enable zero forces discharge output high
// [RQ7] Waking from sleep sets both enables
// [RQ8] Mode status read-only, loaded by recall
// [RQ9] Sleep after 2 s bus low, wake high
// [RQ10] Host programs sleep default in 31h bit 5
// [RQ11] Copy busy blocks writes and new commands
// [RQ12] Lock needs lock enable; enable clears after
// [RQ13] Block lock flags report locked blocks
// [RQ14] Identifier variant has no block 2
// [RQ15] Power switch latch drops low, host restores
// [RQ16] Address byte writes need unlock bit set
// [RQ17] Host clears unlock bit after address write
// [RQ18] Latch catches pin low in any mode
// [RQ19] Read-only and reserved bits ignore writes
`timescale 1ns/100ps
module bmcr_regs
   import bmcr_pkg::*;
#(
   parameter longint SLEEP_CYC  = BMCR_SLEEP_CYC,
   parameter bit     HAS_UID    = 1'b0
) (
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   input  wire logic       fault_hv,
   input  wire logic       fault_lv,
   input  wire logic       fault_coc,
   input  wire logic       fault_doc,
   input  wire logic       chg_block,
   input  wire logic       dis_block,
   input  wire logic       recall_blk1,
   input  wire logic [7:0] nv_byte30,
   input  wire logic [7:0] nv_byte31,
   input  wire logic       nv_cmd_start,
   input  wire logic       nv_cmd_lock,
   input  wire logic [1:0] nv_cmd_blk,
   input  wire logic       nv_cmd_done,
   output logic            nv_cmd_go,
   output logic            nv_wr_ok,
   input  wire logic       scl_pin,
   input  wire logic       sda_pin,
   input  wire logic       psw_n_pin,
   output logic            chg_ctrl_n,
   output logic            dis_ctrl_n,
   output logic            sleep_state,
   output logic      [7:0] slave_addr
);
   localparam int SCW = $clog2(SLEEP_CYC + 1);
   localparam logic [SCW-1:0] SLEEP_LIM = SCW'(SLEEP_CYC);

   logic [2:0] pins_s;
   bmcr_sync #(.W(3)) u_sync (
      .clk_sys  (clk_sys),
      .resetn   (resetn),
      .async_in ({scl_pin, sda_pin, psw_n_pin}),
      .sync_out (pins_s)
   );
   wire scl_s  = pins_s[2];
   wire sda_s  = pins_s[1];
   wire psw_lo = ~pins_s[0];

   logic [3:0]     flags_q;
   logic [1:0]     en_q;
   logic           sleep_en_q;
   logic           busy_q;
   logic           lock_en_q;
   logic [2:0]     blk_lock_q;
   logic           psw_q;
   logic           awu_q;
   logic [7:0]     saddr_q;
   logic           chg_n_q;
   logic           dis_n_q;
   logic           go_q;
   logic           wr_ok_q;
   logic [7:0]     rdata_q;
   logic [SCW-1:0] low_cnt_q;
   logic           boot_q;
   bmcr_mode_t     mode_q;

   // Address decode
   wire wr_prot  = reg_wr && (reg_addr == BMCR_OFS_PROT);
   wire wr_nvc   = reg_wr && (reg_addr == BMCR_OFS_NVC);
   wire wr_feat  = reg_wr && (reg_addr == BMCR_OFS_FEAT);
   wire wr_saddr = reg_wr && (reg_addr == BMCR_OFS_SADDR)
                   && awu_q && !busy_q && !blk_lock_q[1]; // see [RQ16]

   // Fault flags: event wins over host clear
   wire [3:0] fault_ev = {fault_hv, fault_lv, fault_coc, fault_doc};
   wire [3:0] flags_wv = reg_wdata[BMCR_PROT_HV:BMCR_PROT_DOC];
   wire [3:0] flags_d  = fault_ev
                       | (wr_prot ? (flags_q & flags_wv) : flags_q); // see [RQ1]

   // Sleep and wake decisions
   wire bus_low   = !scl_s && !sda_s;
   wire sleep_go  = (mode_q == BMCR_ACTIVE) && sleep_en_q && bus_low
                    && (low_cnt_q == SLEEP_LIM); // see [RQ9]
   wire bus_wake  = sleep_en_q && (scl_s || sda_s);
   wire wake_go   = (mode_q == BMCR_ASLEEP) && (bus_wake || psw_lo);

   // Enables: wake beats recall beats host write
   wire [1:0] en_d = wake_go     ? 2'h3 :                      // see [RQ7]
                     recall_blk1 ? nv_byte30[BMCR_PROT_CE:BMCR_PROT_DE]
                                 :                             // see [RQ3]
                     wr_prot     ? reg_wdata[BMCR_PROT_CE:BMCR_PROT_DE]
                                 : en_q;

   // Nonvolatile command acceptance
   wire lock_ok = nv_cmd_lock ? lock_en_q : 1'b1;             // see [RQ12]
   wire blk_ok  = !(HAS_UID && nv_cmd_blk == 2'h2);           // see [RQ14]
   wire cmd_go  = nv_cmd_start && !busy_q && lock_ok && blk_ok
                  && (nv_cmd_blk != 2'h3);                    // see [RQ11]
   wire [2:0] blk_bit = 3'(1) << nv_cmd_blk;
   // A new command beats a done pulse in the same cycle
   wire busy_d = cmd_go ? 1'b1 : nv_cmd_done ? 1'b0 : busy_q;

   // Power switch latch: low pin beats host write of one
   wire psw_d = psw_lo ? 1'b0 :                               // see [RQ18]
                (wr_feat && reg_wdata[BMCR_FEAT_PSW]) ? 1'b1 : psw_q;

   // Read mux; reserved bits read zero
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         BMCR_OFS_PROT: begin
            rd_mux = {flags_q, chg_n_q, dis_n_q, en_q};      // see [RQ2] [RQ4]
         end
         BMCR_OFS_MODE: begin
            rd_mux[BMCR_MODE_SLEEP] = sleep_en_q;
         end
         BMCR_OFS_NVC: begin
            rd_mux[BMCR_NVC_BUSY]   = busy_q;
            rd_mux[BMCR_NVC_LOCKEN] = lock_en_q;
            rd_mux[BMCR_NVC_BL2:BMCR_NVC_BL0] = blk_lock_q;  // see [RQ13]
         end
         BMCR_OFS_FEAT: begin
            rd_mux[BMCR_FEAT_PSW] = psw_q;
            rd_mux[BMCR_FEAT_AWU] = awu_q;
         end
         BMCR_OFS_SADDR: begin
            rd_mux = saddr_q;
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // Sticky fault flags
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flags_q <= BMCR_FLAGS_RST;
      end else begin
         flags_q <= flags_d;                                  // see [RQ1]
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         en_q <= BMCR_EN_RST;
      end else begin
         en_q <= en_d;
      end
   end

   // Outputs use the next enables so they track the bits without lag
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         chg_n_q <= 1'b1;
         dis_n_q <= 1'b1;
      end else begin
         chg_n_q <= !en_d[1] || chg_block;                    // see [RQ5]
         dis_n_q <= !en_d[0] || dis_block;                    // see [RQ6]
      end
   end

   // Registered read data keeps the decode off the output path
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= rd_mux;
      end
   end

   // Mode status only changes through a recall; first cycle recalls too
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         sleep_en_q <= BMCR_SLEEP_RST;
         boot_q     <= 1'b1;
      end else begin
         boot_q <= 1'b0;
         if (recall_blk1 || boot_q) begin
            sleep_en_q <= nv_byte31[BMCR_MODE_SLEEP];         // see [RQ8]
         end
      end
   end

   // Copy and lock sequencing
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         busy_q  <= 1'b0;
         wr_ok_q <= 1'b1;
         go_q    <= 1'b0;
      end else begin
         busy_q  <= busy_d;                                   // see [RQ11]
         wr_ok_q <= !busy_d;
         go_q    <= cmd_go;
      end
   end

   // Lock marks its block at acceptance and disarms the lock enable
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lock_en_q  <= BMCR_LOCKEN_RST;
         blk_lock_q <= 3'h0;
      end else begin
         if (cmd_go && nv_cmd_lock) begin
            blk_lock_q <= blk_lock_q | blk_bit;
            lock_en_q  <= 1'b0;                               // see [RQ12]
         end else if (wr_nvc) begin
            lock_en_q  <= reg_wdata[BMCR_NVC_LOCKEN];         // see [RQ19]
         end
      end
   end

   // Power switch latch; a held-low pin keeps overriding the host
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         psw_q <= BMCR_PSW_RST;
      end else begin
         psw_q <= psw_d;                                      // see [RQ15]
      end
   end

   // Feature register and address byte
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         awu_q   <= BMCR_AWU_RST;
         saddr_q <= BMCR_SADDR_RST;
      end else begin
         if (wr_feat) begin
            awu_q <= reg_wdata[BMCR_FEAT_AWU];
         end
         if (wr_saddr) begin
            saddr_q <= reg_wdata;
         end else if (recall_blk1) begin
            saddr_q <= saddr_q;
         end
      end
   end

   // Bus-low timer saturates, so a long low cannot wrap and retrigger
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         low_cnt_q <= '0;
      end else if (!bus_low || mode_q != BMCR_ACTIVE) begin
         low_cnt_q <= '0;
      end else if (low_cnt_q != SLEEP_LIM) begin
         low_cnt_q <= low_cnt_q + SCW'(1);
      end
   end

   // Mode state
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         mode_q <= BMCR_ACTIVE;
      end else begin
         case (mode_q)
            BMCR_ACTIVE: begin
               if (sleep_go) begin
                  mode_q <= BMCR_ASLEEP;
               end
            end
            BMCR_ASLEEP: begin
               if (wake_go) begin
                  mode_q <= BMCR_ACTIVE;
               end
            end
            default: begin
               mode_q <= BMCR_ACTIVE;
            end
         endcase
      end
   end

   assign reg_rdata   = rdata_q;
   assign nv_cmd_go   = go_q;
   assign nv_wr_ok    = wr_ok_q;                              // see [RQ11]
   assign chg_ctrl_n  = chg_n_q;
   assign dis_ctrl_n  = dis_n_q;
   // Only the asleep state has bit 0 set, so this is a plain flop bit
   assign sleep_state = mode_q[0];
   assign slave_addr  = saddr_q;
endmodule

// file: bmcr_pkg.sv
// Register map, field positions and reset values of the control registers
package bmcr_pkg;
   localparam logic [7:0] BMCR_OFS_PROT = 8'h00;
   localparam logic [7:0] BMCR_OFS_MODE = 8'h01;
   localparam logic [7:0] BMCR_OFS_NVC  = 8'h07;
   localparam logic [7:0] BMCR_OFS_FEAT = 8'h08;
   localparam logic [7:0] BMCR_OFS_SADDR = 8'h32;
   // Protection register fields
   localparam int BMCR_PROT_HV  = 7;
   localparam int BMCR_PROT_LV  = 6;
   localparam int BMCR_PROT_COC = 5;
   localparam int BMCR_PROT_DOC = 4;
   localparam int BMCR_PROT_CPM = 3;
   localparam int BMCR_PROT_DPM = 2;
   localparam int BMCR_PROT_CE  = 1;
   localparam int BMCR_PROT_DE  = 0;
   // Mode status, nonvolatile control and feature fields
   localparam int BMCR_MODE_SLEEP = 5;
   localparam int BMCR_NVC_BUSY   = 7;
   localparam int BMCR_NVC_LOCKEN = 6;
   localparam int BMCR_NVC_BL2    = 2;
   localparam int BMCR_NVC_BL1    = 1;
   localparam int BMCR_NVC_BL0    = 0;
   localparam int BMCR_FEAT_PSW   = 7;
   localparam int BMCR_FEAT_AWU   = 1;
   // Reset values
   localparam logic [3:0] BMCR_FLAGS_RST = 4'h0;
   localparam logic [1:0] BMCR_EN_RST    = 2'h3;
   localparam logic       BMCR_SLEEP_RST = 1'b0;
   localparam logic       BMCR_PSW_RST   = 1'b1;
   localparam logic       BMCR_AWU_RST   = 1'b0;
   localparam logic       BMCR_LOCKEN_RST = 1'b0;
   localparam logic [7:0] BMCR_SADDR_RST = 8'h68;
   // Sleep entry delay: bus low for more than 2 s
   localparam longint BMCR_SLEEP_MS = 2000;
   localparam longint BMCR_CLK_HZ   = 125000000;
   localparam longint BMCR_SLEEP_CYC = BMCR_SLEEP_MS * BMCR_CLK_HZ / 1000;
   typedef enum logic [1:0] {
      BMCR_ACTIVE = 2'h0,
      BMCR_ASLEEP = 2'h1
   } bmcr_mode_t;
endpackage

// file: bmcr_sync.sv
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/100ps
module bmcr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         // Pins idle high; resetting to one avoids a false low after reset
         meta_q <= '1;
         sync_q <= '1;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
   assign sync_out = sync_q;
endmodule

// file: bmcr_regs_assertions.sv
// Port-level checks of the control register bank
`timescale 1ns/100ps
module bmcr_regs_chk
   import bmcr_pkg::*;
#(
   parameter longint SLEEP_CYC = BMCR_SLEEP_CYC
) (
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic [7:0] reg_addr,
   input wire logic       reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic       fault_hv,
   input wire logic       recall_blk1,
   input wire logic       nv_cmd_start,
   input wire logic       nv_cmd_go,
   input wire logic       nv_wr_ok,
   input wire logic       scl_pin,
   input wire logic       sda_pin,
   input wire logic       chg_ctrl_n,
   input wire logic       dis_ctrl_n,
   input wire logic       sleep_state,
   input wire logic [7:0] slave_addr
);
   // Bits that must read zero at the addressed register
   wire logic [7:0] rsv_mask = (reg_addr == BMCR_OFS_MODE) ? 8'hDF :
      (reg_addr == BMCR_OFS_NVC) ? 8'h38 :
      (reg_addr == BMCR_OFS_FEAT) ? 8'h7D : 8'h00;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   flag_sticky_a: assert property (fault_hv ##1
      (reg_addr == BMCR_OFS_PROT && !reg_wr)[*3] |-> reg_rdata[7])
      else $error("fault flag lost");
   charge_off_a: assert property (reg_wr && reg_addr == 8'h00 &&
      !reg_wdata[1] && !recall_blk1 && !sleep_state |-> ##[1:2] chg_ctrl_n)
      else $error("charge output not off");
   pin_mirror_a: assert property ($past(resetn) &&
      $past(reg_addr) == 8'h00 |->
      reg_rdata[3:2] == {$past(chg_ctrl_n), $past(dis_ctrl_n)})
      else $error("pin mirror wrong");
   reserved_zero_a: assert property (
      (reg_rdata & $past(rsv_mask)) == 8'h00)
      else $error("reserved bit set");
   cmd_accept_a: assert property (nv_cmd_go |->
      $past(nv_cmd_start) && $past(nv_wr_ok))
      else $error("command taken while busy");
   addr_guard_a: assert property ($changed(slave_addr) |->
      $past(reg_wr) && $past(reg_addr) == BMCR_OFS_SADDR)
      else $error("address byte changed");
   sleep_entry_a: assert property ($rose(sleep_state) |->
      !$past(scl_pin, 3) && !$past(sda_pin, 3))
      else $error("sleep with bus high");
   bus_wake_a: assert property (sleep_state && scl_pin |->
      ##[1:4] !sleep_state)
      else $error("no wake on bus high");
   cover property (sleep_state ##1 !sleep_state);
   cover property (nv_cmd_go);
   cover property ($changed(slave_addr));
endmodule
bind bmcr_regs bmcr_regs_chk #(.SLEEP_CYC(SLEEP_CYC)) i_bmcr_regs_chk (
   .clk_sys, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata,
   .fault_hv, .recall_blk1, .nv_cmd_start, .nv_cmd_go, .nv_wr_ok,
   .scl_pin, .sda_pin, .chg_ctrl_n, .dis_ctrl_n, .sleep_state,
   .slave_addr);

// file: bmcr_nv_model.sv
// Nonvolatile engine model: ends copy and lock commands
`timescale 1ns/100ps
module bmcr_nv_model #(
   parameter int LAT = 12
) (
   input  wire logic clk_sys,
   input  wire logic resetn,
   input  wire logic nv_cmd_go,
   output logic      nv_cmd_done
);
   int cnt_q;
   // Long enough that a second request lands while busy
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= 0;
         nv_cmd_done <= 1'b0;
      end else begin
         nv_cmd_done <= (cnt_q == 1);
         cnt_q <= nv_cmd_go ? LAT : (cnt_q != 0) ? cnt_q - 1 : 0;
      end
   end
endmodule

// file: tb_battery_monitor_control_regs.sv
// Testbench for the battery monitor control register bank
`timescale 1ns/100ps
module tb_battery_monitor_control_regs;
   import bmcr_pkg::*;
   logic       clk_sys, resetn, reg_wr, fault_hv, fault_lv, fault_coc;
   logic       fault_doc, chg_block, dis_block, recall_blk1, nv_cmd_start;
   logic       nv_cmd_lock, nv_cmd_done, nv_cmd_go, nv_wr_ok, scl_pin;
   logic       sda_pin, psw_n_pin, chg_ctrl_n, dis_ctrl_n, sleep_state;
   logic [1:0] nv_cmd_blk;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, nv_byte30, nv_byte31;
   logic [7:0] slave_addr;
   int         miscompares, check_count, i;
   bmcr_regs #(.SLEEP_CYC(20)) i_bmcr_regs (.clk_sys, .resetn, .reg_addr,
      .reg_wr, .reg_wdata, .reg_rdata, .fault_hv, .fault_lv, .fault_coc,
      .fault_doc, .chg_block, .dis_block, .recall_blk1, .nv_byte30,
      .nv_byte31, .nv_cmd_start, .nv_cmd_lock, .nv_cmd_blk, .nv_cmd_done,
      .nv_cmd_go, .nv_wr_ok, .scl_pin, .sda_pin, .psw_n_pin, .chg_ctrl_n,
      .dis_ctrl_n, .sleep_state, .slave_addr);
   bmcr_nv_model i_bmcr_nv_model (.clk_sys, .resetn, .nv_cmd_go,
      .nv_cmd_done);
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   // Inputs change 1 ns after the rising edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick(1);
      reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      reg_addr = a;
      tick(2);
      chk(reg_rdata, exp);
   endtask
   task automatic recall(input logic [7:0] b30, input logic [7:0] b31);
      nv_byte30 = b30;
      nv_byte31 = b31;
      recall_blk1 = 1'b1;
      tick(1);
      recall_blk1 = 1'b0;
   endtask
   task automatic cmd(input logic lk, input logic [1:0] b, input logic g);
      logic seen;
      seen = 1'b0;
      nv_cmd_lock = lk;
      nv_cmd_blk = b;
      nv_cmd_start = 1'b1;
      tick(1);
      nv_cmd_start = 1'b0;
      repeat (3) begin
         seen = seen | nv_cmd_go;
         tick(1);
      end
      chk(8'(seen), 8'(g));
   endtask
   initial begin
      #500000;
      miscompares++;
      stop_test;
   end
   initial begin
      {reg_wr, fault_hv, fault_lv, fault_coc, fault_doc, chg_block} = '0;
      {dis_block, recall_blk1, nv_cmd_start, nv_cmd_lock, resetn} = '0;
      {reg_addr, reg_wdata, nv_byte30, nv_cmd_blk} = '0;
      nv_byte31 = 8'h20;
      {scl_pin, sda_pin, psw_n_pin} = 3'h7;
      tick(5);
      resetn = 1'b1;
      tick(2);
      rd(BMCR_OFS_PROT, 8'h03);
      rd(BMCR_OFS_MODE, 8'h20);
      rd(BMCR_OFS_NVC, 8'h00);
      rd(BMCR_OFS_FEAT, 8'h80);
      wr(BMCR_OFS_PROT, 8'hFC);
      rd(BMCR_OFS_PROT, 8'h0C);
      chk(8'({chg_ctrl_n, dis_ctrl_n}), 8'h03);
      wr(BMCR_OFS_PROT, 8'h03);
      {chg_block, dis_block} = 2'h3;
      rd(BMCR_OFS_PROT, 8'h0F);
      {chg_block, dis_block} = 2'h0;
      {fault_hv, fault_lv, fault_coc, fault_doc} = 4'hF;
      tick(1);
      {fault_hv, fault_lv, fault_coc, fault_doc} = 4'h0;
      rd(BMCR_OFS_PROT, 8'hF3);
      wr(BMCR_OFS_PROT, 8'h73);
      rd(BMCR_OFS_PROT, 8'h73);
      // Event and clear in one cycle: the event wins
      fault_lv = 1'b1;
      wr(BMCR_OFS_PROT, 8'h03);
      fault_lv = 1'b0;
      rd(BMCR_OFS_PROT, 8'h43);
      recall(8'h01, 8'h00);
      rd(BMCR_OFS_PROT, 8'h49);
      wr(BMCR_OFS_MODE, 8'hFF);
      rd(BMCR_OFS_MODE, 8'h00);
      {scl_pin, sda_pin} = 2'h0;
      tick(40);
      chk(8'(sleep_state), 8'h00);
      {scl_pin, sda_pin} = 2'h3;
      recall(8'h01, 8'h20);
      wr(BMCR_OFS_PROT, 8'h00);
      {scl_pin, sda_pin} = 2'h0;
      for (i = 0; i < 100 && sleep_state !== 1'b1; i++) tick(1);
      chk(8'(sleep_state), 8'h01);
      scl_pin = 1'b1;
      for (i = 0; i < 20 && sleep_state !== 1'b0; i++) tick(1);
      chk(8'(sleep_state), 8'h00);
      sda_pin = 1'b1;
      rd(BMCR_OFS_PROT, 8'h03);
      // Latch and wake on the power switch pin while asleep
      {scl_pin, sda_pin} = 2'h0;
      for (i = 0; i < 100 && sleep_state !== 1'b1; i++) tick(1);
      chk(8'(sleep_state), 8'h01);
      psw_n_pin = 1'b0;
      tick(4);
      {scl_pin, sda_pin, psw_n_pin} = 3'h7;
      chk(8'(sleep_state), 8'h00);
      rd(BMCR_OFS_FEAT, 8'h00);
      wr(BMCR_OFS_FEAT, 8'h80);
      psw_n_pin = 1'b0;
      tick(4);
      psw_n_pin = 1'b1;
      rd(BMCR_OFS_FEAT, 8'h00);
      wr(BMCR_OFS_FEAT, 8'h80);
      rd(BMCR_OFS_FEAT, 8'h80);
      wr(BMCR_OFS_SADDR, 8'hAA);
      chk(slave_addr, BMCR_SADDR_RST);
      wr(BMCR_OFS_FEAT, 8'h82);
      rd(BMCR_OFS_FEAT, 8'h82);
      wr(BMCR_OFS_SADDR, 8'hAA);
      chk(slave_addr, 8'hAA);
      rd(BMCR_OFS_SADDR, 8'hAA);
      wr(BMCR_OFS_FEAT, 8'h80);
      cmd(1'b1, 2'h1, 1'b0);
      wr(BMCR_OFS_NVC, 8'h40);
      rd(BMCR_OFS_NVC, 8'h40);
      cmd(1'b1, 2'h1, 1'b1);
      chk(8'(nv_wr_ok), 8'h00);
      rd(BMCR_OFS_NVC, 8'h82);
      cmd(1'b0, 2'h0, 1'b0);
      for (i = 0; i < 50 && nv_wr_ok !== 1'b1; i++) tick(1);
      chk(8'(nv_wr_ok), 8'h01);
      rd(BMCR_OFS_NVC, 8'h02);
      cmd(1'b0, 2'h0, 1'b1);
      for (i = 0; i < 50 && nv_wr_ok !== 1'b1; i++) tick(1);
      chk(8'(nv_wr_ok), 8'h01);
      stop_test;
   end
endmodule
